/* logic/csm_core.sv */
// CPU processing-state, exception sequencing and mode control.
// Assumes synchronous inputs on mclk_in and a plain APB master.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module csm_core #(
   parameter int ADDR_W = 18
) (
   input  wire logic              mclk_in,
   input  wire logic              sys_rst_in,
   input  wire logic              clk_en_in,
   input  wire logic              chip_clear_input_n_in,
   input  wire logic              hardware_halt_input_n_in,
   input  wire logic              watchdog_overflow_in,
   input  wire logic              mode_select_pin_hi_in,
   input  wire logic              mode_select_pin_lo_in,
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [ADDR_W-1:0] paddr_in,
   input  wire logic [31:0]       pwdata_in,
   output logic      [31:0]       prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out,
   output logic      [3:0]        cpu_state_out,
   output logic      [7:0]        flags_word_out,
   output logic      [23:0]       branch_addr_out,
   output logic                   clock_stopped_out,
   output logic                   module_reset_out,
   output logic                   mode_valid_out,
   output logic                   wide_space_out,
   output logic                   bus_busy_out,
   output logic                   bus_route_ext_out
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   csm_pkg::csm_state_e state_q;
   csm_pkg::csm_state_e state_d;
   csm_pkg::csm_acc_e   acc_class_q;
   logic [7:0]  sys_cfg_q;
   logic [7:0]  flags_q;
   logic [1:0]  mode_latch_q;
   logic [15:0] area_cfg_q;
   logic [23:0] vector_q;
   logic [23:0] saved_pc_q;
   logic [7:0]  saved_flags_q;
   logic        post_reset_q;
   logic        irq_pend_q;
   logic        nmi_pend_q;
   logic        trap_pend_q;
   logic [1:0]  bus_cnt_q;
   logic [1:0]  bus_len_q;
   logic        ext_route_q;
   logic        reset_req;
   logic        hw_halt;
   logic        apb_setup;
   logic        apb_wr;
   logic        apb_rd;
   logic [15:0] reg_idx;
   logic        hit_mode;
   logic        hit_cfg;
   logic        hit_stat;
   logic        hit_cmd;
   logic        hit_area;
   logic        hit_req;
   logic        cmd_halt;
   logic        cmd_wake;
   logic [2:0]  req_area;
   logic [1:0]  req_class;

   // ----------------------------------------------------------------
   // Request decode
   // ----------------------------------------------------------------
   // Watchdog overflow folds into the same reset request
   assign reset_req = !chip_clear_input_n_in || watchdog_overflow_in;
   assign hw_halt   = !hardware_halt_input_n_in;
   // APB: writes act on the access cycle, read data is registered in the setup cycle, always zero wait
   assign apb_setup = psel_in && !penable_in;
   assign apb_wr    = psel_in && penable_in && pwrite_in;
   assign apb_rd    = psel_in && penable_in && !pwrite_in;
   assign reg_idx   = 16'(paddr_in[ADDR_W-1:2]);
   assign hit_mode  = reg_idx == csm_pkg::MODE_PIN_STATUS_IDX;
   assign hit_cfg   = reg_idx == csm_pkg::SYSTEM_CONFIG_IDX;
   assign hit_stat  = reg_idx == csm_pkg::CPU_STATUS_IDX;
   assign hit_cmd   = reg_idx == csm_pkg::CPU_COMMAND_IDX;
   assign hit_area  = reg_idx == csm_pkg::BUS_AREA_IDX;
   assign hit_req   = reg_idx == csm_pkg::ACCESS_REQ_IDX;
   assign cmd_halt  = apb_wr && hit_cmd && pwdata_in[csm_pkg::CMD_HALT_BIT];
   assign cmd_wake  = apb_wr && hit_cmd && pwdata_in[csm_pkg::CMD_WAKE_BIT];
   assign req_area  = pwdata_in[csm_pkg::REQ_AREA_LSB +: 3];
   assign req_class = pwdata_in[csm_pkg::REQ_MEM_CLASS_LSB +: 2];
   assign pready_out  = 1'b1;
   assign pslverr_out = 1'b0;

   // ----------------------------------------------------------------
   // Processing state machine
   // ----------------------------------------------------------------
   // Reset first, then hardware standby, then exceptions
   always_comb
   begin
      state_d = state_q;
      if (reset_req)
         state_d = csm_pkg::CSM_RESET;
      else if (hw_halt)
         state_d = csm_pkg::CSM_HW_STANDBY;
      else
      begin
         case (state_q)
            csm_pkg::CSM_RESET:      state_d = csm_pkg::CSM_VEC_FETCH;
            csm_pkg::CSM_HW_STANDBY: state_d = csm_pkg::CSM_RESET;
            csm_pkg::CSM_VEC_FETCH:  state_d = csm_pkg::CSM_RUN;
            csm_pkg::CSM_RUN:
               if ((nmi_pend_q || (irq_pend_q && !flags_q[7]))
                   && !post_reset_q)
                  state_d = csm_pkg::CSM_PUSH_PC;
               else if (trap_pend_q)
                  state_d = csm_pkg::CSM_PUSH_PC;
               else if (cmd_halt)
                  state_d = sys_cfg_q[csm_pkg::CFG_DEEP_SLEEP_BIT]
                          ? csm_pkg::CSM_SW_STANDBY
                          : csm_pkg::CSM_SLEEP;
            csm_pkg::CSM_PUSH_PC:    state_d = csm_pkg::CSM_PUSH_FLAGS;
            csm_pkg::CSM_PUSH_FLAGS: state_d = csm_pkg::CSM_MASK;
            csm_pkg::CSM_MASK:       state_d = csm_pkg::CSM_BRANCH;
            csm_pkg::CSM_BRANCH:     state_d = csm_pkg::CSM_RUN;
            csm_pkg::CSM_SLEEP, csm_pkg::CSM_SW_STANDBY:
               if (cmd_wake || nmi_pend_q)
                  state_d = csm_pkg::CSM_RUN;
            default:                 state_d = csm_pkg::CSM_RESET;
         endcase
      end
   end

   // State register
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         state_q <= csm_pkg::CSM_RESET;
      else if (clk_en_in)
         state_q <= state_d;
   end

   // ----------------------------------------------------------------
   // Pending exception requests (set wins over clear)
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in || (clk_en_in && reset_req))
      begin
         irq_pend_q  <= 1'b0;
         nmi_pend_q  <= 1'b0;
         trap_pend_q <= 1'b0;
      end
      else if (clk_en_in)
      begin
         // Retire only the serviced source; a masked one stays pending
         if (apb_wr && hit_cmd && pwdata_in[csm_pkg::CMD_IRQ_BIT])
            irq_pend_q <= 1'b1;
         else if (state_q == csm_pkg::CSM_BRANCH
                  && vector_q == csm_pkg::VECTOR_IRQ)
            irq_pend_q <= 1'b0;
         if (apb_wr && hit_cmd && pwdata_in[csm_pkg::CMD_NMI_BIT])
            nmi_pend_q <= 1'b1;
         else if (state_q == csm_pkg::CSM_BRANCH
                  && vector_q == csm_pkg::VECTOR_NMI)
            nmi_pend_q <= 1'b0;
         if (apb_wr && hit_cmd && pwdata_in[csm_pkg::CMD_TRAP_BIT])
            trap_pend_q <= 1'b1;
         else if (state_q == csm_pkg::CSM_BRANCH
                  && vector_q == csm_pkg::VECTOR_TRAP)
            trap_pend_q <= 1'b0;
      end
   end

   // Interrupts stay blocked for one run state after reset sequence
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         post_reset_q <= 1'b1;
      else if (clk_en_in)
         post_reset_q <= state_q == csm_pkg::CSM_RESET
                      || state_q == csm_pkg::CSM_VEC_FETCH;
   end

   // ----------------------------------------------------------------
   // Flags word, stacking and vector
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         flags_q       <= csm_pkg::FLAGS_RST;
         saved_pc_q    <= 24'h000000;
         saved_flags_q <= 8'h00;
         vector_q      <= csm_pkg::VECTOR_RESET;
      end
      else if (clk_en_in)
      begin
         if (state_q == csm_pkg::CSM_RESET)
         begin
            flags_q[csm_pkg::FLAG_GLOBAL_BIT] <= 1'b1;
            vector_q <= csm_pkg::VECTOR_RESET;
         end
         else if (state_q == csm_pkg::CSM_PUSH_PC)
         begin
            saved_pc_q <= vector_q;
            vector_q   <= nmi_pend_q ? csm_pkg::VECTOR_NMI
                        : (irq_pend_q && !flags_q[7]) ? csm_pkg::VECTOR_IRQ
                        : csm_pkg::VECTOR_TRAP;
         end
         else if (state_q == csm_pkg::CSM_PUSH_FLAGS)
            saved_flags_q <= flags_q;
         else if (state_q == csm_pkg::CSM_MASK)
         begin
            flags_q[csm_pkg::FLAG_GLOBAL_BIT] <= 1'b1;
            if (!sys_cfg_q[csm_pkg::CFG_USER_FLAG_BIT])
               flags_q[csm_pkg::FLAG_SECONDARY_BIT] <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Configuration register
   // ----------------------------------------------------------------
   // Hardware standby resets modules; memory enable kept in sw standby
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in || (clk_en_in && (reset_req || hw_halt)))
         sys_cfg_q <= csm_pkg::SYSTEM_CONFIG_RST;
      else if (clk_en_in && apb_wr && hit_cfg)
      begin
         sys_cfg_q <= pwdata_in[7:0];
         sys_cfg_q[csm_pkg::CFG_RSVD_ONE_BIT] <= 1'b1;
      end
   end

   // Area table: per area a width bit and a length bit
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in || (clk_en_in && (reset_req || hw_halt)))
         area_cfg_q <= csm_pkg::BUS_AREA_RST;
      else if (clk_en_in && apb_wr && hit_area)
         area_cfg_q <= pwdata_in[15:0];
   end

   // ----------------------------------------------------------------
   // Bus cycle timing
   // ----------------------------------------------------------------
   // Each requested cycle holds busy for its documented state count
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in || (clk_en_in && reset_req))
      begin
         bus_cnt_q   <= 2'd0;
         bus_len_q   <= 2'd0;
         ext_route_q <= 1'b0;
         acc_class_q <= csm_pkg::CSM_ACC_ONCHIP;
      end
      else if (clk_en_in)
      begin
         if (apb_wr && hit_req && bus_cnt_q == 2'd0
             && state_q == csm_pkg::CSM_RUN)
         begin
            if (req_class == 2'd0
                && sys_cfg_q[csm_pkg::CFG_MEM_ON_BIT])
            begin
               acc_class_q <= csm_pkg::CSM_ACC_ONCHIP;
               bus_len_q   <= csm_pkg::STATES_ONCHIP_MEM;
               ext_route_q <= 1'b0;
            end
            else if (req_class == 2'd1)
            begin
               acc_class_q <= csm_pkg::CSM_ACC_PERIPH;
               bus_len_q   <= csm_pkg::STATES_PERIPH;
               ext_route_q <= 1'b0;
            end
            else
            begin
               // Disabled memory falls through to the external bus
               acc_class_q <= csm_pkg::CSM_ACC_EXT;
               bus_len_q   <= area_cfg_q[{1'b1, req_area}]
                            ? csm_pkg::STATES_LONG
                            : csm_pkg::STATES_SHORT;
               ext_route_q <= 1'b1;
            end
            bus_cnt_q <= 2'd1;
         end
         else if (bus_cnt_q != 2'd0)
            bus_cnt_q <= (bus_cnt_q == bus_len_q) ? 2'd0
                       : bus_cnt_q + 2'd1;
      end
   end

   // ----------------------------------------------------------------
   // Register read path
   // ----------------------------------------------------------------
   // Mode pins captured at read time; fixed bits forced
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         mode_latch_q <= 2'b00;
      else if (clk_en_in && apb_setup && !pwrite_in && hit_mode)
         mode_latch_q <= {mode_select_pin_hi_in,
                          mode_select_pin_lo_in};
   end

   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         prdata_out <= 32'h00000000;
      else if (clk_en_in && apb_setup && !pwrite_in)
      begin
         if (hit_mode)
            prdata_out <= {24'h000000, csm_pkg::MODE_STATUS_FIXED[7:2],
                           mode_select_pin_hi_in,
                           mode_select_pin_lo_in};
         else if (hit_cfg)
            prdata_out <= {24'h000000, sys_cfg_q};
         else if (hit_stat)
            prdata_out <= {1'b0, ext_route_q, bus_cnt_q, 4'(state_q),
                           saved_flags_q, flags_q, 8'h00};
         else if (hit_area)
            prdata_out <= {16'h0000, area_cfg_q};
         else if (hit_req)
            prdata_out <= {8'h00, saved_pc_q};
         else
            prdata_out <= 32'h00000000;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Mode legality: only 01 and 11 are defined
   assign mode_valid_out    = mode_latch_q[0];
   assign wide_space_out    = mode_latch_q == 2'b11;
   assign cpu_state_out     = 4'(state_q);
   assign flags_word_out    = flags_q;
   assign branch_addr_out   = vector_q;
   assign clock_stopped_out = state_q == csm_pkg::CSM_SW_STANDBY
                           || state_q == csm_pkg::CSM_HW_STANDBY;
   assign module_reset_out  = clock_stopped_out
                           || state_q == csm_pkg::CSM_RESET;
   assign bus_busy_out      = bus_cnt_q != 2'd0;
   assign bus_route_ext_out = ext_route_q
                           && acc_class_q == csm_pkg::CSM_ACC_EXT;
endmodule : csm_core
`default_nettype wire

/* inc/csm_pkg.sv */
// Package for the CPU state and mode control block.
// Assumes an APB slave with 32-bit data and one word per register.
package csm_pkg;
   // ----------------------------------------------------------------
   // Register map (printed offsets are indices, byte address = 4*index)
   // ----------------------------------------------------------------
   localparam logic [15:0] MODE_PIN_STATUS_IDX = 16'hFFF1;
   localparam logic [15:0] SYSTEM_CONFIG_IDX   = 16'hFFF2;
   localparam logic [15:0] CPU_STATUS_IDX      = 16'hFFF4;
   localparam logic [15:0] CPU_COMMAND_IDX     = 16'hFFF5;
   localparam logic [15:0] BUS_AREA_IDX        = 16'hFFF6;
   localparam logic [15:0] ACCESS_REQ_IDX      = 16'hFFF7;
   localparam logic [7:0]  SYSTEM_CONFIG_RST   = 8'h0B;
   localparam logic [7:0]  MODE_STATUS_FIXED   = 8'hC0;
   localparam logic [7:0]  FLAGS_RST           = 8'h80;
   localparam logic [15:0] BUS_AREA_RST        = 16'h0000;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CFG_DEEP_SLEEP_BIT  = 7;
   localparam int CFG_USER_FLAG_BIT   = 3;
   localparam int CFG_RSVD_ONE_BIT    = 1;
   localparam int CFG_MEM_ON_BIT      = 0;
   localparam int FLAG_GLOBAL_BIT     = 7;
   localparam int FLAG_SECONDARY_BIT  = 6;
   localparam int CMD_HALT_BIT        = 0;
   localparam int CMD_IRQ_BIT         = 1;
   localparam int CMD_NMI_BIT         = 2;
   localparam int CMD_TRAP_BIT        = 3;
   localparam int CMD_WAKE_BIT        = 4;
   localparam int REQ_MEM_CLASS_LSB   = 0;
   localparam int REQ_AREA_LSB        = 4;
   // ----------------------------------------------------------------
   // Timing counts (states) and exception vector addresses
   // ----------------------------------------------------------------
   localparam logic [1:0] STATES_ONCHIP_MEM = 2'd2;
   localparam logic [1:0] STATES_PERIPH     = 2'd3;
   localparam logic [1:0] STATES_SHORT      = 2'd2;
   localparam logic [1:0] STATES_LONG       = 2'd3;
   localparam logic [2:0] STACK_STEPS       = 3'd2;
   localparam logic [23:0] VECTOR_RESET     = 24'h000000;
   localparam logic [23:0] VECTOR_NMI       = 24'h00001C;
   localparam logic [23:0] VECTOR_TRAP      = 24'h000020;
   localparam logic [23:0] VECTOR_IRQ       = 24'h000030;
   // ----------------------------------------------------------------
   // Processing states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      CSM_RESET, CSM_VEC_FETCH, CSM_RUN, CSM_PUSH_PC, CSM_PUSH_FLAGS,
      CSM_MASK, CSM_BRANCH, CSM_SLEEP, CSM_SW_STANDBY, CSM_HW_STANDBY
   } csm_state_e;
   // Access classes
   typedef enum logic [1:0] {
      CSM_ACC_ONCHIP, CSM_ACC_PERIPH, CSM_ACC_EXT
   } csm_acc_e;
endpackage : csm_pkg

/* testbench/csm_core_asserts.sv */
// Checker for the state and mode control block, bound to its ports.
// Assumes clk_en_in is held high while sequences are judged.
`timescale 1ns/1ps
`default_nettype none
module csm_core_asserts #(
   parameter int ADDR_W = 18
) (
   input wire logic              mclk_in,
   input wire logic              sys_rst_in,
   input wire logic              clk_en_in,
   input wire logic              chip_clear_input_n_in,
   input wire logic              hardware_halt_input_n_in,
   input wire logic              watchdog_overflow_in,
   input wire logic              mode_select_pin_hi_in,
   input wire logic              mode_select_pin_lo_in,
   input wire logic              psel_in,
   input wire logic              penable_in,
   input wire logic              pwrite_in,
   input wire logic [ADDR_W-1:0] paddr_in,
   input wire logic [31:0]       prdata_out,
   input wire logic [3:0]        cpu_state_out,
   input wire logic [7:0]        flags_word_out,
   input wire logic              clock_stopped_out,
   input wire logic              module_reset_out
);
   // Any clear, halt or freeze cuts a sequence short
   wire logic live = clk_en_in && chip_clear_input_n_in &&
                     hardware_halt_input_n_in && !watchdog_overflow_in;
   localparam logic [ADDR_W-1:0] MODE_ADDR =
      ADDR_W'({csm_pkg::MODE_PIN_STATUS_IDX, 2'b00});
   default clocking cb @(posedge mclk_in); endclocking
   // Stacking steps of an interrupt or trap
   sequence s_stack;
      cpu_state_out == csm_pkg::CSM_PUSH_PC ##1
      cpu_state_out == csm_pkg::CSM_PUSH_FLAGS ##1
      cpu_state_out == csm_pkg::CSM_MASK ##1
      cpu_state_out == csm_pkg::CSM_BRANCH;
   endsequence
   a_clear_holds: assert property (disable iff (sys_rst_in)
      clk_en_in && !chip_clear_input_n_in |=>
      cpu_state_out == csm_pkg::CSM_RESET) else $error("clear ignored");
   a_wdog_reset: assert property (disable iff (sys_rst_in)
      clk_en_in && watchdog_overflow_in |=>
      cpu_state_out == csm_pkg::CSM_RESET) else $error("wdog ignored");
   a_reset_mask: assert property (disable iff (sys_rst_in)
      cpu_state_out == csm_pkg::CSM_RESET |-> flags_word_out[7])
      else $error("mask clear in reset");
   a_clear_rise: assert property (disable iff (sys_rst_in || !live)
      $rose(chip_clear_input_n_in) |->
      ##[1:2] cpu_state_out == csm_pkg::CSM_VEC_FETCH)
      else $error("no vector fetch after clear");
   a_fetch_guard: assert property (disable iff (sys_rst_in)
      cpu_state_out == csm_pkg::CSM_VEC_FETCH |=>
      (cpu_state_out != csm_pkg::CSM_PUSH_PC) [*2])
      else $error("exception right after reset");
   a_stack_order: assert property (disable iff (sys_rst_in || !live)
      cpu_state_out == csm_pkg::CSM_PUSH_PC |-> s_stack)
      else $error("stacking order broken");
   a_branch_mask: assert property (disable iff (sys_rst_in)
      cpu_state_out == csm_pkg::CSM_BRANCH |-> flags_word_out[7])
      else $error("global mask not set");
   a_branch_run: assert property (disable iff (sys_rst_in || !live)
      cpu_state_out == csm_pkg::CSM_BRANCH |=>
      cpu_state_out == csm_pkg::CSM_RUN) else $error("no branch");
   a_hw_standby: assert property (disable iff (sys_rst_in)
      clk_en_in && chip_clear_input_n_in && !watchdog_overflow_in &&
      !hardware_halt_input_n_in |=> cpu_state_out ==
      csm_pkg::CSM_HW_STANDBY && clock_stopped_out && module_reset_out)
      else $error("hardware standby missed");
   a_sw_standby: assert property (disable iff (sys_rst_in)
      cpu_state_out == csm_pkg::CSM_SW_STANDBY |->
      clock_stopped_out && module_reset_out) else $error("standby open");
   a_mode_read: assert property (disable iff (sys_rst_in)
      clk_en_in && psel_in && !penable_in && !pwrite_in &&
      paddr_in == MODE_ADDR |=> prdata_out == {24'h000000, 6'h30,
      $past(mode_select_pin_hi_in), $past(mode_select_pin_lo_in)})
      else $error("mode status wrong");
endmodule : csm_core_asserts
bind csm_core csm_core_asserts #(.ADDR_W(ADDR_W)) u_chk (.mclk_in,
   .sys_rst_in, .clk_en_in, .chip_clear_input_n_in,
   .hardware_halt_input_n_in, .watchdog_overflow_in,
   .mode_select_pin_hi_in, .mode_select_pin_lo_in, .psel_in, .penable_in,
   .pwrite_in, .paddr_in, .prdata_out, .cpu_state_out, .flags_word_out,
   .clock_stopped_out, .module_reset_out);
`default_nettype wire

/* testbench/csm_board_model.sv */
// Board model: strap levels on the two mode pins.
// Assumes a board that never moves the straps while running.
`timescale 1ns/1ps
`default_nettype none
module csm_board_model #(
   parameter logic MODE_HI = 1'b1,
   parameter logic MODE_LO = 1'b1
) (
   output logic mode_hi_out,
   output logic mode_lo_out
);
   // Fixed straps from MODE_HI and MODE_LO, mode 3 by default, steady for the whole run
   assign mode_hi_out = MODE_HI;
   assign mode_lo_out = MODE_LO;
endmodule : csm_board_model
`default_nettype wire

/* testbench/tb_cpu_state_and_mode_control.sv */
// Testbench for the state and mode control block over APB.
// Assumes the board straps mode 3; clk_en_in stays high except for the three-cycle freeze check in t_power.
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_state_and_mode_control;
   logic        clk = 1'b0, rst = 1'b1, clr_n = 1'b1, hwh_n = 1'b1;
   logic        wdog = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic        en = 1'b1;
   logic [17:0] paddr = 18'h00000;
   logic [31:0] pwd = 32'h00000000, prd, d;
   logic        mhi, mlo, rdy, err, cstop, mrst, mval, wide, busy, ext;
   logic [3:0]  st;
   logic [7:0]  flg;
   logic [23:0] vec;
   int          n_fail = 0, checks = 0, cyc = 0;
   csm_board_model board (.mode_hi_out(mhi), .mode_lo_out(mlo));
   csm_core dut (.mclk_in(clk), .sys_rst_in(rst), .clk_en_in(en),
      .chip_clear_input_n_in(clr_n), .hardware_halt_input_n_in(hwh_n),
      .watchdog_overflow_in(wdog), .mode_select_pin_hi_in(mhi),
      .mode_select_pin_lo_in(mlo), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd),
      .prdata_out(prd), .pready_out(rdy), .pslverr_out(err),
      .cpu_state_out(st), .flags_word_out(flg), .branch_addr_out(vec),
      .clock_stopped_out(cstop), .module_reset_out(mrst),
      .mode_valid_out(mval), .wide_space_out(wide),
      .bus_busy_out(busy), .bus_route_ext_out(ext));
   // Clock at 25 MHz; a hang is cut short by the cycle ceiling
   initial forever #20 clk = ~clk;
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // One APB transfer; request held until pready is seen high
   task automatic apb(logic w, logic [15:0] idx, logic [31:0] wd);
      @(posedge clk);
      {psel, pwr, paddr, pwd} <= {1'b1, w, idx, 2'b00, wd};
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      chk("pslverr", 32'h00000000, err);
      d = prd;
      {psel, pen} <= 2'b00;
   endtask : apb
   task automatic wait_st(logic [3:0] s);
      for (int i = 0; i < 60 && st !== s; i++) @(posedge clk);
      chk("cpu_state", s, st);
   endtask : wait_st
   // Clear or watchdog held three cycles, then the reset sequence
   task automatic do_clear(logic by_wdog);
      @(posedge clk);
      if (by_wdog) wdog <= 1'b1;
      else clr_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk("cpu_state", csm_pkg::CSM_RESET, st);
      {wdog, clr_n} <= 2'b01;
      wait_st(csm_pkg::CSM_VEC_FETCH);
      wait_st(csm_pkg::CSM_RUN);
      chk("branch_addr", csm_pkg::VECTOR_RESET, vec);
      chk("flags_global", 32'h00000001, flg[7]);
   endtask : do_clear
   task automatic t_regs();
      apb(0, csm_pkg::MODE_PIN_STATUS_IDX, 0);
      chk("mode_pin_status", 32'h000000C3, d);
      apb(1, csm_pkg::MODE_PIN_STATUS_IDX, 32'hFFFFFFFF);
      apb(0, csm_pkg::MODE_PIN_STATUS_IDX, 0);
      chk("mode_pin_status", 32'h000000C3, d);
      chk("mode_flags", 2'b11, {mval, wide});
      apb(0, csm_pkg::SYSTEM_CONFIG_IDX, 0);
      chk("system_config", csm_pkg::SYSTEM_CONFIG_RST, d);
      apb(1, csm_pkg::SYSTEM_CONFIG_IDX, 0);
      apb(0, csm_pkg::SYSTEM_CONFIG_IDX, 0);
      chk("system_config", 32'h00000002, d);
      apb(0, 16'h0010, 0);
      chk("unmapped", 32'h00000000, d);
      do_clear(1'b1);
      apb(0, csm_pkg::SYSTEM_CONFIG_IDX, 0);
      chk("system_config", csm_pkg::SYSTEM_CONFIG_RST, d);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_exc();
      apb(1, csm_pkg::CPU_COMMAND_IDX, 32'h2);
      repeat (10) @(posedge clk);
      chk("branch_addr", csm_pkg::VECTOR_RESET, vec);
      apb(1, csm_pkg::CPU_COMMAND_IDX, 32'h8);
      wait_st(csm_pkg::CSM_BRANCH);
      chk("flags_word", 8'h80, flg);
      wait_st(csm_pkg::CSM_RUN);
      chk("branch_addr", csm_pkg::VECTOR_TRAP, vec);
      apb(1, csm_pkg::SYSTEM_CONFIG_IDX, 32'h03);
      apb(1, csm_pkg::CPU_COMMAND_IDX, 32'h4);
      wait_st(csm_pkg::CSM_BRANCH);
      chk("flags_word", 8'hC0, flg);
      wait_st(csm_pkg::CSM_RUN);
      chk("branch_addr", csm_pkg::VECTOR_NMI, vec);
      apb(1, csm_pkg::CPU_COMMAND_IDX, 32'h8);
      do_clear(1'b0);
      $display("t_exc done");
   endtask : t_exc
   task automatic t_power();
      apb(1, csm_pkg::CPU_COMMAND_IDX, 32'h1);
      wait_st(csm_pkg::CSM_SLEEP);
      chk("sleep_regs", {1'b0, 8'hC0}, {cstop, flg});
      do_clear(1'b0);
      apb(1, csm_pkg::SYSTEM_CONFIG_IDX, 32'h8B);
      apb(1, csm_pkg::CPU_COMMAND_IDX, 32'h1);
      wait_st(csm_pkg::CSM_SW_STANDBY);
      chk("standby_regs", {2'b11, 8'hC0}, {cstop, mrst, flg});
      do_clear(1'b0);
      hwh_n <= 1'b0;
      wait_st(csm_pkg::CSM_HW_STANDBY);
      apb(1, csm_pkg::CPU_COMMAND_IDX, 32'h1);
      chk("cpu_state", csm_pkg::CSM_HW_STANDBY, st);
      hwh_n <= 1'b1;
      wait_st(csm_pkg::CSM_RUN);
      // Enable low: a hardware halt must not move the frozen state
      {en, hwh_n} <= 2'b00;
      repeat (3) @(posedge clk);
      chk("frozen_state", csm_pkg::CSM_RUN, st);
      {en, hwh_n} <= 2'b11;
      $display("t_power done");
   endtask : t_power
   // Rows: area config, system config, request, states, external
   logic [15:0] ar[5] = '{16'h0, 16'h0, 16'h0, 16'h2000, 16'h0};
   logic [7:0]  cf[5] = '{8'h0B, 8'h0B, 8'h0A, 8'h0B, 8'h0B};
   logic [7:0]  rq[5] = '{8'h00, 8'h01, 8'h00, 8'h52, 8'h52};
   logic [2:0]  ex[5] = '{3'h2, 3'h3, 3'h6, 3'h7, 3'h6};
   task automatic t_bus();
      int n;
      for (int k = 0; k < 5; k++)
      begin
         apb(1, csm_pkg::BUS_AREA_IDX, ar[k]);
         apb(1, csm_pkg::SYSTEM_CONFIG_IDX, cf[k]);
         apb(1, csm_pkg::ACCESS_REQ_IDX, rq[k]);
         for (int i = 0; i < 10 && busy !== 1'b1; i++) @(posedge clk);
         chk("route_ext", ex[k][2], ext);
         for (n = 0; n < 10 && busy === 1'b1; n++) @(posedge clk);
         chk("bus_states", ex[k][1:0], n);
      end
      $display("t_bus done");
   endtask : t_bus
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      wait_st(csm_pkg::CSM_RUN);
      t_regs();
      t_exc();
      t_power();
      t_bus();
      end_sim();
   end
endmodule : tb_cpu_state_and_mode_control
`default_nettype wire
